/* shared/fmc_pkg.sv */
// Package: constants and types for the firmware memory cycle host
package fmc_pkg;
  localparam logic [3:0] START_READ = 4'hd;
  localparam logic [3:0] START_WRITE = 4'he;
  localparam logic [3:0] SIZE_SINGLE = 4'h0;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] SYNC_WAIT = 4'h5;
  localparam logic [3:0] SYNC_ERROR = 4'ha;
  localparam logic [3:0] TAR_NIBBLE = 4'hf;
  localparam logic [2:0] ADDR_NIBBLES = 3'h7;
  localparam int SYNC_TIMEOUT_NS = 10000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [9:0] SYNC_LIMIT = 10'(SYNC_TIMEOUT_CYC);
  localparam int BUS_DIV = 3;
  localparam logic [1:0] BUS_DIV_LAST = 2'(BUS_DIV - 1);

  typedef struct packed {
    logic write;
    logic [3:0] dev_sel;
    logic [27:0] addr;
    logic [7:0] data;
  } fmc_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic timeout;
  } fmc_rsp_t;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_START = 10'h002,
    ST_SEL = 10'h004,
    ST_ADDR = 10'h008,
    ST_SIZE = 10'h010,
    ST_WDATA = 10'h020,
    ST_TAR1 = 10'h040,
    ST_SYNC = 10'h080,
    ST_RDATA = 10'h100,
    ST_TAR2 = 10'h200
  } fmc_state_t;
endpackage

/* design/fmc_host.sv */
// Host controller that runs single-byte firmware memory cycles on the bus
// Operation
// - Frame strobe low with start code
// - Read start code is 1101
// - Write start code is 1110
// - One device-select nibble follows start
// - Seven clocks of 28-bit address
// - Size nibble zero, single byte only
// - Read: host drives turnaround after preamble
// - Write: two-clock data phase after size
// - Write: turnaround, sync ready/error, turnaround
// - Write closing sequence exactly five clocks
// - Host never aborts cycle on errors; here a read that reaches the sync timeout skips its data phase and ends
// - Address sent most significant nibble first
module fmc_host
  import fmc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_req_valid,
  input wire fmc_req_t i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output fmc_rsp_t o_rsp,
  output logic o_bus_clk,
  output logic o_frame_strobe_n,
  output logic [3:0] o_ad,
  output logic o_ad_oe,
  input wire logic [3:0] i_ad
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus clock divider: 100 MHz / 3 gives the 33 MHz bus rate
  logic [1:0] div_ff, nxt_div;
  logic bus_clk_ff, nxt_bus_clk;
  logic tick;

  always_comb begin
    tick = (div_ff == BUS_DIV_LAST);
    nxt_div = tick ? 2'h0 : div_ff + 2'h1;
    nxt_bus_clk = (div_ff == 2'h0);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      div_ff <= 2'h0;
      bus_clk_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      bus_clk_ff <= nxt_bus_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser for the nibble bus
  logic [3:0] ad_s1_ff, ad_s2_ff;
  logic [3:0] nxt_ad_s1, nxt_ad_s2;

  always_comb begin
    nxt_ad_s1 = i_ad;
    nxt_ad_s2 = ad_s1_ff;
  end

  // Reset to the idle bus level so a stale ready code is never seen
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      ad_s1_ff <= TAR_NIBBLE;
      ad_s2_ff <= TAR_NIBBLE;
    end else begin
      ad_s1_ff <= nxt_ad_s1;
      ad_s2_ff <= nxt_ad_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer, advances once per bus tick outside idle
  fmc_state_t st_ff, nxt_st;
  fmc_req_t req_ff, nxt_req;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [9:0] wait_ff, nxt_wait;
  logic [7:0] rdata_ff, nxt_rdata;
  logic frame_n_ff, nxt_frame_n;
  logic [3:0] ad_ff, nxt_ad;
  logic oe_ff, nxt_oe;
  logic rdy_ff, nxt_rdy;
  logic rsp_v_ff, nxt_rsp_v;
  fmc_rsp_t rsp_ff, nxt_rsp;
  logic tout_ff, nxt_tout;

  always_comb begin
    nxt_st = st_ff;
    nxt_req = req_ff;
    nxt_cnt = cnt_ff;
    nxt_frame_n = frame_n_ff;
    nxt_ad = ad_ff;
    nxt_oe = oe_ff;
    nxt_rdy = rdy_ff;
    case (st_ff)
      ST_IDLE: begin
        nxt_rdy = 1'b1;
        if (i_req_valid && rdy_ff) begin
          nxt_req = i_req;
          nxt_rdy = 1'b0;
          nxt_st = ST_START;
        end
      end
      ST_START: begin
        if (tick) begin
          nxt_frame_n = 1'b0;
          nxt_oe = 1'b1;
          nxt_ad = req_ff.write ? START_WRITE : START_READ;
          nxt_st = ST_SEL;
        end
      end
      ST_SEL: begin
        if (tick) begin
          nxt_frame_n = 1'b1;
          nxt_ad = req_ff.dev_sel;
          nxt_cnt = 3'h0;
          nxt_st = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (tick) begin
          nxt_ad = req_ff.addr[27:24];
          nxt_req.addr = {req_ff.addr[23:0], 4'h0};
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == ADDR_NIBBLES - 3'h1) begin
            nxt_st = ST_SIZE;
          end
        end
      end
      ST_SIZE: begin
        if (tick) begin
          nxt_ad = SIZE_SINGLE;
          nxt_cnt = 3'h0;
          nxt_st = req_ff.write ? ST_WDATA : ST_TAR1;
        end
      end
      ST_WDATA: begin
        if (tick) begin
          nxt_ad = (cnt_ff == 3'h0) ? req_ff.data[3:0]
                                    : req_ff.data[7:4];
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == 3'h1) begin
            nxt_cnt = 3'h0;
            nxt_st = ST_TAR1;
          end
        end
      end
      ST_TAR1: begin
        if (tick) begin
          // First clock drives all ones, second releases the bus
          nxt_ad = TAR_NIBBLE;
          nxt_oe = (cnt_ff == 3'h0);
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == 3'h1) begin
            nxt_cnt = 3'h0;
            nxt_st = ST_SYNC;
          end
        end
      end
      ST_SYNC: begin
        if (tick) begin
          nxt_oe = 1'b0;
          // Writes take exactly one sync clock whatever is seen
          if (req_ff.write) begin
            nxt_st = ST_TAR2;
          end else if (ad_s2_ff == SYNC_READY) begin
            nxt_st = ST_RDATA;
          end else if (wait_ff == SYNC_LIMIT) begin
            nxt_st = ST_TAR2;
          end
        end
      end
      ST_RDATA: begin
        if (tick) begin
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == 3'h1) begin
            nxt_cnt = 3'h0;
            nxt_st = ST_TAR2;
          end
        end
      end
      ST_TAR2: begin
        if (tick) begin
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == 3'h1) begin
            nxt_cnt = 3'h0;
            nxt_st = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_st = ST_IDLE;
        nxt_oe = 1'b0;
        nxt_frame_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_ff <= ST_IDLE;
      req_ff <= '0;
      cnt_ff <= 3'h0;
      frame_n_ff <= 1'b1;
      ad_ff <= TAR_NIBBLE;
      oe_ff <= 1'b0;
      rdy_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      req_ff <= nxt_req;
      cnt_ff <= nxt_cnt;
      frame_n_ff <= nxt_frame_n;
      ad_ff <= nxt_ad;
      oe_ff <= nxt_oe;
      rdy_ff <= nxt_rdy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync guard, read data and response, judged at bus ticks. The pin
  // synchroniser and the tick phase put each target nibble two ticks late,
  // and o_rsp is loaded only at the end so it holds between responses
  always_comb begin
    nxt_wait = wait_ff;
    nxt_rdata = rdata_ff;
    nxt_tout = tout_ff;
    nxt_rsp_v = 1'b0;
    nxt_rsp = rsp_ff;
    if (tick) begin
      case (st_ff)
        ST_START: begin
          nxt_wait = 10'h0;
          nxt_tout = 1'b0;
        end
        ST_SYNC: begin
          nxt_wait = wait_ff + 10'h1;
          if (!req_ff.write && ad_s2_ff != SYNC_READY &&
              wait_ff == SYNC_LIMIT) begin
            // Guard against a missing target; no abort mid-cycle otherwise
            nxt_tout = 1'b1;
          end
        end
        ST_RDATA: begin
          if (cnt_ff == 3'h0) begin
            nxt_rdata[3:0] = ad_s2_ff;
          end else begin
            nxt_rdata[7:4] = ad_s2_ff;
          end
        end
        ST_TAR2: begin
          if (cnt_ff == 3'h1) begin
            nxt_rsp.data = rdata_ff;
            nxt_rsp.timeout = tout_ff;
            if (req_ff.write) begin
              // Write sync is seen here, two ticks after the target drove it
              nxt_rsp.data = req_ff.data;
              nxt_rsp.timeout = (ad_s2_ff != SYNC_READY);
            end
            nxt_rsp_v = 1'b1;
          end
        end
        default: begin
          nxt_wait = wait_ff;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      wait_ff <= 10'h0;
      rdata_ff <= 8'h00;
      tout_ff <= 1'b0;
      rsp_v_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      tout_ff <= nxt_tout;
      rsp_v_ff <= nxt_rsp_v;
      rsp_ff <= nxt_rsp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  always_comb begin
    o_bus_clk = bus_clk_ff;
    o_frame_strobe_n = frame_n_ff;
    o_ad = ad_ff;
    o_ad_oe = oe_ff;
    o_req_ready = rdy_ff;
    o_rsp_valid = rsp_v_ff;
    o_rsp = rsp_ff;
  end

endmodule

/* dv/fmc_host_chk.sv */
// Port checker for the firmware memory cycle host
module fmc_host_chk
  import fmc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_req_valid,
  input wire fmc_req_t i_req,
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire logic o_frame_strobe_n,
  input wire logic [3:0] o_ad,
  input wire logic o_ad_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////////
  // Request held here since the bus fields are judged against it later
  fmc_req_t q_ff;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) q_ff <= '0;
    else if (i_req_valid && o_req_ready) q_ff <= i_req;
  end
  ////////////////////////////////////////////////////////////////////////
  property p_start;
    $fell(o_frame_strobe_n) |-> o_ad_oe &&
      o_ad == (q_ff.write ? START_WRITE : START_READ);
  endproperty
  a_start: assert property (p_start) else $error("start");
  property p_sel;
    $fell(o_frame_strobe_n) |-> !o_frame_strobe_n[*3] ##1
      (o_frame_strobe_n && o_ad == q_ff.dev_sel);
  endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_addr;
    $fell(o_frame_strobe_n) |-> ##6 o_ad == q_ff.addr[27:24]
      ##18 o_ad == q_ff.addr[3:0];
  endproperty
  a_addr: assert property (p_addr) else $error("address");
  property p_size;
    $fell(o_frame_strobe_n) |-> ##27 o_ad_oe && o_ad == SIZE_SINGLE;
  endproperty
  a_size: assert property (p_size) else $error("size");
  property p_wdata;
    $fell(o_frame_strobe_n) && q_ff.write |-> ##30 o_ad == q_ff.data[3:0]
      ##3 o_ad == q_ff.data[7:4];
  endproperty
  a_wdata: assert property (p_wdata) else $error("wdata");
  property p_rtar;
    $fell(o_frame_strobe_n) && !q_ff.write |-> ##30
      (o_ad_oe && o_ad == TAR_NIBBLE) ##3 !o_ad_oe;
  endproperty
  a_rtar: assert property (p_rtar) else $error("read tar");
  property p_roff;
    $fell(o_frame_strobe_n) && !q_ff.write |-> ##36 !o_ad_oe ##3 !o_ad_oe;
  endproperty
  a_roff: assert property (p_roff) else $error("read off");
  property p_wtar;
    $fell(o_frame_strobe_n) && q_ff.write |-> ##36
      (o_ad_oe && o_ad == TAR_NIBBLE) ##3 !o_ad_oe;
  endproperty
  a_wtar: assert property (p_wtar) else $error("write tar");
  property p_wlen;
    $fell(o_frame_strobe_n) && q_ff.write |-> ##48 o_rsp_valid;
  endproperty
  a_wlen: assert property (p_wlen) else $error("write len");
  property p_take;
    i_req_valid && o_req_ready |=> !o_req_ready;
  endproperty
  a_take: assert property (p_take) else $error("take");
endmodule
bind fmc_host fmc_host_chk i_chk (.*);

/* dv/fmc_flash_model.sv */
// Behavioural firmware memory device on the nibble bus
module fmc_flash_model
  import fmc_pkg::*;
#(
  parameter logic [3:0] ID = 4'h3,
  parameter int WAITS = 2
)(
  input wire logic i_bus_clk,
  input wire logic i_host_oe,
  input wire logic [3:0] i_host_ad,
  input wire logic i_frame_strobe_n,
  input wire logic i_err,
  output logic [3:0] o_ad
);
  logic [7:0] mem [16];
  logic [27:0] a;
  logic [3:0] ad, lo;
  logic drv, flt, wr, ok, hit;
  int n, s, ws;
  initial begin
    drv = 0; flt = 0; n = 99; ad = 0; hit = 0; wr = 0; ok = 0;
  end
  // Released bus toggles so a stale value never reads as ready
  assign o_ad = i_host_oe ? i_host_ad : drv ? ad : (flt ? 4'h9 : 4'h6);
  always @(posedge i_bus_clk) begin
    s = n - (wr ? 14 : 12);
    ws = wr ? 0 : WAITS;
    flt <= !flt;
    if (!i_frame_strobe_n) begin
      n <= 1;
      wr <= i_host_ad == START_WRITE;
      ok <= i_host_ad == START_WRITE || i_host_ad == START_READ;
    end else if (n < 99) begin
      n <= n + 1;
      if (n == 1) hit <= ok && i_host_ad == ID;
      if (n >= 2 && n <= 8) a <= {a[23:0], i_host_ad};
      if (n == 10) lo <= i_host_ad;
      if (n == 11 && wr && hit) mem[a[3:0]] <= {i_host_ad, lo};
      if (s >= 0) begin
        drv <= hit && s < ws + (wr ? 2 : 4);
        if (s < ws) ad <= SYNC_WAIT;
        else if (s == ws) ad <= wr && i_err ? SYNC_ERROR : SYNC_READY;
        else if (!wr && s == ws + 1) ad <= mem[a[3:0]][3:0];
        else if (!wr && s == ws + 2) ad <= mem[a[3:0]][7:4];
        else ad <= TAR_NIBBLE;
      end
    end
  end
endmodule

/* dv/fmc_host_test.sv */
// Self-checking bench for the firmware memory cycle host
module fmc_host_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fmc_pkg::*;
  logic clk = 0, rst_b = 0, vld = 0, err = 0;
  logic rdy, rv, bclk, frn, hoe;
  logic [3:0] had, ad;
  fmc_req_t req = '0;
  fmc_rsp_t rsp, r;
  int fail_count = 0, cmp_count = 0;
  always #5 clk = !clk;
  fmc_host i_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_req_valid(vld),
    .i_req(req), .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp(rsp),
    .o_bus_clk(bclk), .o_frame_strobe_n(frn), .o_ad(had), .o_ad_oe(hoe),
    .i_ad(ad));
  fmc_flash_model #(.ID(4'h3), .WAITS(2)) i_mem (.i_bus_clk(bclk),
    .i_host_oe(hoe), .i_host_ad(had), .i_frame_strobe_n(frn),
    .i_err(err), .o_ad(ad));
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // Offer one request, then wait a bounded time for its answer
  task automatic xfer(input logic w, input logic [3:0] s,
      input logic [27:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    req <= '{w, s, a, d};
    vld <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk);
      if (rdy === 1'b1) break;
    end
    if (i == 50) begin
      fail_count++;
      tally_and_finish();
    end
    @(posedge clk);
    vld <= 1'b0;
    for (i = 0; i < 5000; i++) begin
      @(negedge clk);
      if (rv === 1'b1) break;
    end
    if (i == 5000) begin
      fail_count++;
      tally_and_finish();
    end
    r = rsp;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_write_read;
    xfer(1'b1, 4'h3, 28'h876543a, 8'hc5);
    cmp("wr", 9'h18a, r);
    xfer(1'b0, 4'h3, 28'h876543a, 8'h00);
    cmp("rd", 9'h18a, r);
  endtask
  task automatic s_write_error;
    err <= 1'b1;
    xfer(1'b1, 4'h3, 28'hfffffff, 8'h3c);
    cmp("wr err", 9'h079, r);
    err <= 1'b0;
    xfer(1'b0, 4'h3, 28'hfffffff, 8'h00);
    cmp("rd back", 9'h078, r);
  endtask
  task automatic s_wrong_select;
    xfer(1'b0, 4'h4, 28'h876543a, 8'h00);
    cmp("timeout", 9'h001, {8'h00, r.timeout});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    s_write_read();
    s_write_error();
    s_wrong_select();
    tally_and_finish();
  end
endmodule
